// ===== common/mmtmr_consts.svh
`ifndef MMTMR_CONSTS_SVH
`define MMTMR_CONSTS_SVH

// Register byte offsets on the APB
`define MMTMR_OFF_CNT 8'h00
`define MMTMR_OFF_CMP 8'h04
`define MMTMR_OFF_PWM 8'h08
`define MMTMR_OFF_CTRL_A 8'h0C
`define MMTMR_OFF_CTRL_B 8'h10
`define MMTMR_OFF_CTRL_C 8'h14
`define MMTMR_OFF_INTFL 8'h18

// Reset and reload values
`define MMTMR_CNT_RST 32'h00000000
`define MMTMR_CNT_RELOAD 32'h00000001
`define MMTMR_CMP_RST 32'hFFFFFFFF
`define MMTMR_PWM_RST 32'h00000000
`define MMTMR_CTRL_C_RST 10'h000

// Field positions, half width and largest prescaler divide
`define MMTMR_STAT_BIT 19
`define MMTMR_RDY_LSB 10
`define MMTMR_HALF_W 16
`define MMTMR_PRESC_MAX 4096

`endif

// ===== common/mmtmr_pkg.sv
package mmtmr_pkg;

  // Operating modes, values as written to the mode field
  typedef enum logic [3:0] {
    MMTMR_ONESHOT = 4'h0,
    MMTMR_CONT = 4'h1,
    MMTMR_COUNTER = 4'h2,
    MMTMR_PWM = 4'h3,
    MMTMR_CAPTURE = 4'h4,
    MMTMR_COMPARE = 4'h5,
    MMTMR_GATED = 4'h6,
    MMTMR_CAPCMP = 4'h7
  } mmtmr_mode_e;

  // Counter organisation
  typedef enum logic [1:0] {
    MMTMR_CASC32 = 2'h0,
    MMTMR_DUAL16 = 2'h1,
    MMTMR_SINGLE16 = 2'h2
  } mmtmr_width_e;

  // Per-half control word, bits 18:0 of a half control register
  typedef struct packed {
    logic pol;
    logic clken;
    logic en;
    logic [11:0] div;
    logic [3:0] mode;
  } mmtmr_half_s;

  // Shared control word, bits 9:0 of the common control register
  typedef struct packed {
    logic [1:0] width;
    logic [1:0] we;
    logic [1:0] ie;
    logic [1:0] sel_b;
    logic [1:0] sel_a;
  } mmtmr_ctrl_s;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mmtmr_apb_req_s;

endpackage

// ===== design/mmtmr_core.sv
// The address map and the APB register port were decided locally.
`include "mmtmr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mmtmr_core #(
  parameter bit LOW_POWER = 1'b0
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // APB slave
  input wire mmtmr_pkg::mmtmr_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources 1..3, asynchronous
  input wire logic [2:0] src_clk_in,
  input wire logic lp_sleep,
  // Timer pins, one per half
  input wire logic [1:0] tmr_in,
  output logic [1:0] tmr_out,
  output logic [1:0] tmr_out_oe,
  // Events
  output logic irq,
  output logic wake
);
  import mmtmr_pkg::*;

  if (LOW_POWER !== 1'b0 && LOW_POWER !== 1'b1) begin : g_chk
    $error("mmtmr_core: LOW_POWER must be 0 or 1");
  end

  ////////////////////////////////////////////////////////////////////////
  // Field helpers

  // Extract a half's view of a 32-bit word
  function automatic logic [31:0] fld(input logic [31:0] w,
                                      input int h, input logic wide);
    if (wide)
      return w;
    else if (h == 0)
      return {16'h0000, w[15:0]};
    else
      return {16'h0000, w[31:16]};
  endfunction

  // Write a half's view back into a 32-bit word
  function automatic logic [31:0] put(input logic [31:0] w,
                                      input int h, input logic wide,
                                      input logic [31:0] v);
    if (wide)
      return v;
    else if (h == 0)
      return {w[31:16], v[15:0]};
    else
      return {v[15:0], w[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [31:0] cnt_r, cmp_r, pwm_r;
  logic [31:0] cnt_nxt;
  mmtmr_half_s hc_r [2];
  mmtmr_ctrl_s cc_r;
  logic [1:0] flag_r, busy_r, rdy_r;
  logic [11:0] pre_r [2];
  logic [2:0] src_s1_r, src_s2_r, src_d_r;
  logic [1:0] in_s1_r, in_s2_r, lvl_d_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [1:0] out_r, oe_r;
  logic irq_r, wake_r;

  // Combinational per-half terms
  logic wide;
  logic [1:0] act, src_tick, tclk, lvl, rise, fall, inc, cap, end_ev;
  logic [1:0] run;
  logic wr_acc, setup;

  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_acc = apb_req.psel && apb_req.penable && pready_r &&
                  apb_req.pwrite;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two flops on every asynchronous input; the edge detectors look
  // only at the second stage so metastability cannot leak in
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      src_s1_r <= 3'h0;
      src_s2_r <= 3'h0;
      src_d_r <= 3'h0;
      in_s1_r <= 2'h0;
      in_s2_r <= 2'h0;
    end else if (clk_en) begin
      src_s1_r <= src_clk_in;
      src_s2_r <= src_s1_r;
      src_d_r <= src_s2_r;
      in_s1_r <= tmr_in;
      in_s2_r <= in_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-half event decode

  // Half B only exists in dual mode of a standard instance; the
  // low-power build is always one 32-bit timer
  always_comb begin
    logic [1:0] sel;
    logic src_edge;
    sel = 2'h0;
    src_edge = 1'b0;
    wide = LOW_POWER || (cc_r.width == MMTMR_CASC32);
    act[0] = 1'b1;
    act[1] = !LOW_POWER && (cc_r.width == MMTMR_DUAL16);
    for (int h = 0; h < 2; h++) begin
      // Wide modes and low-power take half A's select
      if (h == 0 || wide)
        sel = cc_r.sel_a;
      else
        sel = cc_r.sel_b;
      // Source 0 is the bus clock itself; it stops in low-power sleep
      case (sel)
        2'h0: src_edge = !(LOW_POWER && lp_sleep);
        2'h1: src_edge = src_s2_r[0] && !src_d_r[0];
        2'h2: src_edge = src_s2_r[1] && !src_d_r[1];
        default: src_edge = src_s2_r[2] && !src_d_r[2];
      endcase
      src_tick[h] = src_edge && act[h];
      run[h] = act[h] && hc_r[h].en && hc_r[h].clken;
      // Prescaler wraps at div, giving divide by div+1
      tclk[h] = run[h] && src_tick[h] &&
                (pre_r[h] == hc_r[h].div);
      lvl[h] = in_s2_r[h] ^ hc_r[h].pol;
      rise[h] = run[h] && lvl[h] && !lvl_d_r[h];
      fall[h] = run[h] && !lvl[h] && lvl_d_r[h];
      inc[h] = 1'b0;
      cap[h] = 1'b0;
      case (hc_r[h].mode)
        MMTMR_COUNTER: inc[h] = rise[h];
        MMTMR_CAPTURE: begin
          inc[h] = tclk[h];
          cap[h] = rise[h];
        end
        MMTMR_GATED: inc[h] = tclk[h] && lvl[h];
        MMTMR_CAPCMP: begin
          inc[h] = tclk[h] && lvl[h];
          cap[h] = fall[h];
        end
        MMTMR_ONESHOT, MMTMR_CONT, MMTMR_PWM,
        MMTMR_COMPARE: inc[h] = tclk[h];
        default: inc[h] = 1'b0;
      endcase
      // Count that already equals compare ends the period on the
      // next count event instead of incrementing
      end_ev[h] = cap[h] || (inc[h] &&
        fld(cnt_r, h, wide) == fld(cmp_r, h, wide));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescalers and input level history

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pre_r[0] <= 12'h000;
      pre_r[1] <= 12'h000;
      lvl_d_r <= 2'h0;
    end else if (clk_en) begin
      for (int h = 0; h < 2; h++) begin
        // Held at zero while stopped so a restart gives a full divide
        if (!run[h])
          pre_r[h] <= 12'h000;
        else if (src_tick[h])
          pre_r[h] <= (pre_r[h] == hc_r[h].div) ? 12'h000 :
                      pre_r[h] + 12'h001;
      end
      lvl_d_r <= lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter register

  // Next count built half by half, so in dual mode half B's update
  // stacks on half A's instead of replacing it
  always_comb begin
    cnt_nxt = cnt_r;
    for (int h = 0; h < 2; h++) begin
      if (end_ev[h])
        cnt_nxt = put(cnt_nxt, h, wide, `MMTMR_CNT_RELOAD);
      else if (inc[h])
        cnt_nxt = put(cnt_nxt, h, wide,
                      fld(cnt_r, h, wide) + 32'h1);
    end
  end

  // Software writes take priority over a count event in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= `MMTMR_CNT_RST;
    end else if (clk_en) begin
      if (wr_acc && apb_req.paddr == `MMTMR_OFF_CNT)
        cnt_r <= apb_req.pwdata;
      else
        cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and PWM registers; capture lands in the PWM register

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmp_r <= `MMTMR_CMP_RST;
    end else if (clk_en && wr_acc && apb_req.paddr == `MMTMR_OFF_CMP) begin
      cmp_r <= apb_req.pwdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwm_r <= `MMTMR_PWM_RST;
    end else if (clk_en) begin
      if (wr_acc && apb_req.paddr == `MMTMR_OFF_PWM)
        pwm_r <= apb_req.pwdata;
      else if (cap[0] && cap[1])
        pwm_r <= {cnt_r[31:16], cnt_r[15:0]};
      else if (cap[0])
        pwm_r <= put(pwm_r, 0, wide, fld(cnt_r, 0, wide));
      else if (cap[1])
        pwm_r <= put(pwm_r, 1, wide, fld(cnt_r, 1, wide));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  // Configuration changes are only safe while disabled; the block
  // does not guard against a live change
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hc_r[0] <= '0;
      hc_r[1] <= '0;
      cc_r <= mmtmr_ctrl_s'(`MMTMR_CTRL_C_RST);
    end else if (clk_en) begin
      if (wr_acc && apb_req.paddr == `MMTMR_OFF_CTRL_A)
        hc_r[0] <= apb_req.pwdata[18:0];
      if (wr_acc && apb_req.paddr == `MMTMR_OFF_CTRL_B)
        hc_r[1] <= apb_req.pwdata[18:0];
      if (wr_acc && apb_req.paddr == `MMTMR_OFF_CTRL_C)
        cc_r <= apb_req.pwdata[9:0];
      // One-shot end clears enable, overriding a same-cycle write
      for (int h = 0; h < 2; h++) begin
        if (end_ev[h] && hc_r[h].mode == MMTMR_ONESHOT)
          hc_r[h].en <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock status

  // Busy lags enable by one cycle, so status reads zero only once
  // the counting logic has stopped; ready needs a real source edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_r <= 2'h0;
      rdy_r <= 2'h0;
    end else if (clk_en) begin
      for (int h = 0; h < 2; h++) begin
        busy_r[h] <= hc_r[h].en;
        if (!hc_r[h].clken)
          rdy_r[h] <= 1'b0;
        else if (src_tick[h])
          rdy_r[h] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags and wake

  // Write one to clear; a period end in the same cycle wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_r <= 2'h0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else if (clk_en) begin
      for (int h = 0; h < 2; h++) begin
        if (end_ev[h])
          flag_r[h] <= 1'b1;
        else if (wr_acc && apb_req.paddr == `MMTMR_OFF_INTFL &&
                 apb_req.pwdata[h])
          flag_r[h] <= 1'b0;
      end
      irq_r <= |(flag_r & cc_r.ie);
      wake_r <= |(flag_r & cc_r.we);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer outputs

  // Idle level is the polarity bit; enables follow output modes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_r <= 2'h0;
      oe_r <= 2'h0;
    end else if (clk_en) begin
      for (int h = 0; h < 2; h++) begin
        case (hc_r[h].mode)
          MMTMR_ONESHOT: begin
            out_r[h] <= hc_r[h].pol ^ end_ev[h];
            oe_r[h] <= act[h] && hc_r[h].clken;
          end
          MMTMR_CONT, MMTMR_COMPARE: begin
            if (!run[h])
              out_r[h] <= hc_r[h].pol;
            else if (end_ev[h])
              out_r[h] <= !out_r[h];
            oe_r[h] <= act[h] && hc_r[h].clken;
          end
          MMTMR_PWM: begin
            out_r[h] <= hc_r[h].pol ^ (run[h] &&
              fld(cnt_r, h, wide) >= fld(pwm_r, h, wide));
            oe_r[h] <= act[h] && hc_r[h].clken;
          end
          default: begin
            out_r[h] <= hc_r[h].pol;
            oe_r[h] <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  // No wait states: ready rises in the access phase after setup,
  // read data is captured from the setup-phase address
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (clk_en) begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
        case (apb_req.paddr)
          `MMTMR_OFF_CNT: prdata_r <= cnt_r;
          `MMTMR_OFF_CMP: prdata_r <= cmp_r;
          `MMTMR_OFF_PWM: prdata_r <= pwm_r;
          `MMTMR_OFF_CTRL_A: prdata_r <= {12'h000,
            hc_r[0].clken && (hc_r[0].en || busy_r[0]),
            hc_r[0]};
          `MMTMR_OFF_CTRL_B: prdata_r <= {12'h000,
            hc_r[1].clken && (hc_r[1].en || busy_r[1]),
            hc_r[1]};
          `MMTMR_OFF_CTRL_C: prdata_r <= {20'h00000, rdy_r,
            cc_r};
          `MMTMR_OFF_INTFL: prdata_r <= {30'h00000000, flag_r};
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tmr_out = out_r;
  assign tmr_out_oe = oe_r;
  assign irq = irq_r;
  assign wake = wake_r;

endmodule // mmtmr_core

`default_nettype wire

// ===== verification/mmtmr_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmtmr_consts.svh"
module mmtmr_props (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register bus
  input wire mmtmr_pkg::mmtmr_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic [2:0] src_clk_in,
  input wire logic lp_sleep,
  input wire logic [1:0] tmr_in,
  input wire logic [1:0] tmr_out,
  input wire logic [1:0] tmr_out_oe,
  input wire logic irq,
  input wire logic wake
);
  import mmtmr_pkg::*;
  logic [1:0] ie_r;
  logic [1:0] we_r;
  logic [3:0] mode_r;
  logic pol_r;
  logic [1:0] quiet_r;
  logic wr;
  logic os;
  ////////////////////////////////////////
  // Shadow of enables, taken where the bus write lands
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
  assign os = mode_r == MMTMR_ONESHOT && quiet_r == 2'h3;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ie_r <= 2'h0;
      we_r <= 2'h0;
    end else if (clk_en && wr && apb_req.paddr == `MMTMR_OFF_CTRL_C) begin
      ie_r <= apb_req.pwdata[5:4];
      we_r <= apb_req.pwdata[7:6];
    end
  end
  // Mode shadow; the pin may settle a few cycles after a mode write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_r <= 4'h0;
      pol_r <= 1'b0;
      quiet_r <= 2'h0;
    end else if (clk_en && wr && apb_req.paddr == `MMTMR_OFF_CTRL_A) begin
      mode_r <= apb_req.pwdata[3:0];
      pol_r <= apb_req.pwdata[18];
      quiet_r <= 2'h0;
    end else if (quiet_r != 2'h3) begin
      quiet_r <= quiet_r + 2'h1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  apb_answer_a: assert property (
    apb_req.psel && !apb_req.penable |=> pready)
    else $error("No answer after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("Ready stood too long");
  bad_offset_a: assert property (pready |-> pslverr ==
    (apb_req.paddr > 8'h18 || apb_req.paddr[1:0] != 2'h0))
    else $error("Error response wrong");
  reset_clear_a: assert property (disable iff (1'b0)
    sys_rst && clk_en |=> !irq && !wake && !pready && tmr_out == 2'h0)
    else $error("Outputs not cleared by reset");
  irq_mask_a: assert property (irq |-> $past(ie_r) != 2'h0)
    else $error("Interrupt while disabled");
  wake_mask_a: assert property (wake |-> $past(we_r) != 2'h0)
    else $error("Wake while disabled");
  pulse_once_a: assert property (
    os && $changed(tmr_out[0]) && tmr_out[0] != pol_r |=> tmr_out[0] == pol_r)
    else $error("One-shot pulse not one cycle");
  os_flag_a: assert property (
    os && ie_r[0] && $changed(tmr_out[0]) |-> ##[0:1] irq)
    else $error("One-shot end without interrupt");
  rsvd_zero_a: assert property (pready && !apb_req.pwrite &&
    apb_req.paddr == `MMTMR_OFF_INTFL |-> prdata[31:2] == 30'h0)
    else $error("Reserved flag bits not zero");
  cover property (irq);
  cover property (pready && pslverr);
  cover property (os && $changed(tmr_out[0]));
endmodule // mmtmr_props

bind mmtmr_core mmtmr_props u_mmtmr_props (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_clk_in(src_clk_in), .lp_sleep(lp_sleep), .tmr_in(tmr_in),
  .tmr_out(tmr_out), .tmr_out_oe(tmr_out_oe), .irq(irq), .wake(wake)
);
`default_nettype wire

// ===== verification/mmtmr_pins.sv
`timescale 1ns/1ps
`default_nettype none
module mmtmr_pins (
  // Source clocks and timer inputs
  output logic [2:0] src_clk_in,
  output logic [1:0] tmr_in
);
  initial begin
    src_clk_in = 3'h0;
    tmr_in = 2'h0;
  end
  // Free-running oscillators, phase unrelated to the bus clock
  always #85 src_clk_in = src_clk_in + 3'h1;
  // Edges land off the clock grid, so the core must synchronise them
  task automatic pulse(input int h, input int n);
    repeat (n) begin
      #213 tmr_in[h] = 1'b1;
      #207 tmr_in[h] = 1'b0;
    end
  endtask
  task automatic hold(input int h, input logic v);
    #17 tmr_in[h] = v;
  endtask
endmodule // mmtmr_pins
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmtmr_consts.svh"
module testbench;
  import mmtmr_pkg::*;
  // Bus table row: write, offset, data, expected read, expected error
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } mmtmr_row_s;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic lp_sleep = 1'b0;
  mmtmr_apb_req_s apb_req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] src_clk_in;
  logic [1:0] tmr_in;
  logic [1:0] tmr_out;
  logic [1:0] tmr_out_oe;
  logic irq;
  logic wake;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  int gap_n;
  logic [31:0] rd;
  logic [31:0] c0;
  logic er;
  mmtmr_row_s rows [10] = '{
    '{1'b0, 8'h00, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, 8'h14, 32'h0, 32'h00000000, 1'b0},
    '{1'b1, 8'h04, 32'h12345678, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h12345678, 1'b0},
    '{1'b1, 8'h00, 32'h0000ABCD, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h0000ABCD, 1'b0},
    '{1'b0, 8'h1C, 32'h0, 32'h00000000, 1'b1},
    '{1'b1, 8'h20, 32'hFFFFFFFF, 32'h0, 1'b1}};
  ////////////////////////////////////////
  always #20 clock = ~clock;
  mmtmr_core u_mmtmr_core (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_clk_in(src_clk_in), .lp_sleep(lp_sleep), .tmr_in(tmr_in),
    .tmr_out(tmr_out), .tmr_out_oe(tmr_out_oe), .irq(irq), .wake(wake));
  mmtmr_pins u_mmtmr_pins (.src_clk_in(src_clk_in), .tmr_in(tmr_in));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Master holds the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk(pready, 1'b1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 30);
    chk(rd & m, v);
  endtask
  // Cycles between two changes of the half A output
  task automatic gap();
    logic v;
    v = tmr_out[0];
    gap_n = 0;
    do begin
      @(posedge clock);
      gap_n++;
    end while (tmr_out[0] === v && gap_n < 300);
  endtask
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("FAIL %0t timeout", $time);
      results();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].x);
      chk(er, rows[i].e);
    end
    $display("Register table done");
    // Continuous, compare 3, divide by 2, equal selects
    apb(1'b1, `MMTMR_OFF_CMP, 32'h00000003);
    apb(1'b1, `MMTMR_OFF_CTRL_C, 32'h00000010);
    apb(1'b1, `MMTMR_OFF_CNT, 32'h00000000);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00020011);
    poll(`MMTMR_OFF_CTRL_C, 32'h00000400, 32'h00000400);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00030011);
    gap();
    gap();
    chk(gap_n, 6);
    gap();
    chk(gap_n, 6);
    apb(1'b0, `MMTMR_OFF_CNT, 32'h0);
    chk(rd >= 1 && rd <= 3, 1'b1);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00020011);
    poll(`MMTMR_OFF_CTRL_A, 32'h00080000, 32'h0);
    $display("Continuous test done");
    // One-shot with interrupt and wake enabled
    apb(1'b1, `MMTMR_OFF_INTFL, 32'h00000003);
    apb(1'b1, `MMTMR_OFF_CMP, 32'h00000002);
    apb(1'b1, `MMTMR_OFF_CNT, 32'h00000000);
    apb(1'b1, `MMTMR_OFF_CTRL_C, 32'h00000050);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00020000);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00030000);
    repeat (30) @(posedge clock);
    chk(irq, 1'b1);
    chk(wake, 1'b1);
    apb(1'b0, `MMTMR_OFF_INTFL, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b0, `MMTMR_OFF_CNT, 32'h0);
    chk(rd, `MMTMR_CNT_RELOAD);
    apb(1'b0, `MMTMR_OFF_CTRL_A, 32'h0);
    chk(rd[16], 1'b0);
    apb(1'b1, `MMTMR_OFF_CTRL_C, 32'h00000040);
    @(posedge clock);
    chk(irq, 1'b0);
    chk(wake, 1'b1);
    apb(1'b1, `MMTMR_OFF_INTFL, 32'h00000001);
    @(posedge clock);
    chk(wake, 1'b0);
    $display("One-shot test done");
    // Counter mode counts pin edges
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00020002);
    apb(1'b1, `MMTMR_OFF_CNT, 32'h0);
    apb(1'b1, `MMTMR_OFF_CMP, 32'hFFFFFFFF);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00030002);
    u_mmtmr_pins.pulse(0, 5);
    repeat (6) @(posedge clock);
    apb(1'b0, `MMTMR_OFF_CNT, 32'h0);
    chk(rd, 32'h00000005);
    $display("Counter test done");
    // Gated mode holds while the pin is low
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00020006);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00030006);
    apb(1'b0, `MMTMR_OFF_CNT, 32'h0);
    c0 = rd;
    apb(1'b0, `MMTMR_OFF_CNT, 32'h0);
    chk(rd, c0);
    u_mmtmr_pins.hold(0, 1'b1);
    repeat (10) @(posedge clock);
    apb(1'b0, `MMTMR_OFF_CNT, 32'h0);
    chk(rd > c0, 1'b1);
    u_mmtmr_pins.hold(0, 1'b0);
    @(posedge clock);
    $display("Gated test done");
    // Capture snapshots the running count on a pin edge
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00020004);
    apb(1'b1, `MMTMR_OFF_CNT, 32'h0);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00030004);
    repeat (20) @(posedge clock);
    u_mmtmr_pins.pulse(0, 1);
    repeat (6) @(posedge clock);
    apb(1'b0, `MMTMR_OFF_PWM, 32'h0);
    chk(rd != 32'h0, 1'b1);
    apb(1'b0, `MMTMR_OFF_INTFL, 32'h0);
    chk(rd[0], 1'b1);
    $display("Capture test done");
    // Dual 16-bit: both halves count every clock, independently
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00020001);
    apb(1'b1, `MMTMR_OFF_CNT, 32'h0);
    apb(1'b1, `MMTMR_OFF_CTRL_C, 32'h00000100);
    apb(1'b1, `MMTMR_OFF_CTRL_B, 32'h00030001);
    apb(1'b1, `MMTMR_OFF_CTRL_A, 32'h00030001);
    repeat (20) @(posedge clock);
    apb(1'b0, `MMTMR_OFF_CNT, 32'h0);
    chk(rd[15:0] > 16'h000A, 1'b1);
    chk(rd[31:16] > rd[15:0], 1'b1);
    $display("Dual test done");
    results();
  end
endmodule // testbench
`default_nettype wire
